// file: cmt_map.svh
/*
  Offsets, field positions, reset values and timing figures of the
  core-memory timing and parity block.
  Assumes inclusion by bare name from the top module.
*/
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH

// Timing
`define CMT_CLK_NS 10
`define CMT_OSC_NS 60
`define CMT_OSC_CYCLES (`CMT_OSC_NS / `CMT_CLK_NS)

// Register byte offsets
`define CMT_OFF_CTRL 4'h0
`define CMT_OFF_STATUS 4'h4
`define CMT_OFF_ERR 4'h8
`define CMT_OFF_CYCLES 4'hC

// Control fields
`define CMT_CTRL_EN 0
`define CMT_CTRL_CHK 1
`define CMT_CTRL_RST 2'h3

// Status fields
`define CMT_ST_RUN 0
`define CMT_ST_PHASE 1
`define CMT_ST_SEQ_LO 2
`define CMT_ST_RDFLAG 6
`define CMT_ST_RXPAR 7
`define CMT_ST_GENPAR 8

// Error field
`define CMT_ERR_PFAIL 0

// AXI responses
`define CMT_RESP_OKAY 2'h0
`define CMT_RESP_SLVERR 2'h2

`endif

// file: cmt_pkg.sv
/*
  Types shared by the core-memory timing and parity block.
  Assumes cmt_map.svh is on the include path.
*/
package cmt_pkg;

  // Twisted-ring stages a..d plus the read/write phase and run state
  typedef struct packed {
    logic run;
    logic e;
    logic d;
    logic c;
    logic b;
    logic a;
  } cmt_seq_s;

  // Drive pulses to the memory modules, active high
  typedef struct packed {
    logic early_read_pulse;
    logic late_read_pulse;
    logic inhibit_drive_pulse;
    logic write_drive_pulse;
  } cmt_drive_s;

  typedef enum logic [0:0] {
    CMT_WR_IDLE = 1'b0,
    CMT_WR_RESP = 1'b1
  } cmt_wr_state_e;

endpackage

// file: cmt_core_memory_timing.sv
/*
  Core-memory cycle timing generator with parity generation and check,
  with an AXI4-Lite register slave.
  Assumes one 100 MHz clock; start strobes and memory buses arrive from
  outside this clock domain and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmt_map.svh"

module cmt_core_memory_timing
  import cmt_pkg::*;
#(
  parameter int OSC_CYCLES = `CMT_OSC_CYCLES,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Cycle requests
  input wire logic dma_cycle_start,
  input wire logic cpu_cycle_start,
  input wire logic cpu_read_req,
  input wire logic channel_write_active,
  // Processor status and module strap
  input wire logic cpu_memory_busy,
  input wire logic cpu_busy_hold,
  input wire logic data_bus_busy_n,
  input wire logic parity_module_present,
  // Memory buses
  input wire logic [DATA_W-1:0] memory_data_bus,
  input wire logic [DATA_W:0] memory_sense_bus,
  // Memory drive and parity
  output cmt_drive_s drive_q,
  output logic generated_parity_bit,
  output logic parity_write_bit,
  output logic read_cycle_flag,
  output logic parity_fail_flag,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SYNC_W = 2 * DATA_W + 8;

  // Parity over a word; low when the active bit count is even
  function automatic logic odd_parity(input logic [DATA_W-1:0] v);
    odd_parity = ^v;
  endfunction

  // Two-flop synchronisers for every pin input outside the AXI4-Lite port and reset_n
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  assign pin_raw = {dma_cycle_start, cpu_cycle_start, cpu_read_req,
                    channel_write_active, cpu_memory_busy, cpu_busy_hold,
                    data_bus_busy_n, parity_module_present,
                    memory_data_bus, memory_sense_bus[DATA_W-1:0]};

  logic sense_par1_q;
  logic sense_par2_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sense_par1_q <= 1'b0;
      sense_par2_q <= 1'b0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sense_par1_q <= memory_sense_bus[DATA_W];
      sense_par2_q <= sense_par1_q;
    end
  end

  logic dma_start_s, cpu_start_s, cpu_read_s, chan_wr_s;
  logic cpu_busy_s, busy_hold_s, dbus_busy_n_s, par_present_s;
  logic [DATA_W-1:0] mdata_s;
  assign {dma_start_s, cpu_start_s, cpu_read_s, chan_wr_s, cpu_busy_s,
          busy_hold_s, dbus_busy_n_s, par_present_s, mdata_s} =
         sync2_q[SYNC_W-1:DATA_W];

  // Software control
  logic ctrl_en_q;
  logic ctrl_chk_q;

  // Start edge detection; a strobe held high starts only one cycle
  logic dma_prev_q;
  logic cpu_prev_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dma_prev_q <= 1'b0;
      cpu_prev_q <= 1'b0;
    end else begin
      dma_prev_q <= dma_start_s;
      cpu_prev_q <= cpu_start_s;
    end
  end

  cmt_seq_s seq_q;
  logic cpu_evt, dma_evt, start_evt;
  assign cpu_evt = cpu_start_s && !cpu_prev_q;
  assign dma_evt = dma_start_s && !dma_prev_q;
  // Starts arriving during a cycle are dropped, the requester must retry
  assign start_evt = ctrl_en_q && !seq_q.run && (cpu_evt || dma_evt);

  // Oscillator: one toggle every OSC_CYCLES clocks while running
  logic [7:0] osc_cnt_q;
  logic tick;
  assign tick = seq_q.run && (osc_cnt_q == 8'(OSC_CYCLES - 1));
  always_ff @(posedge sys_clk) begin
    if (!reset_n || start_evt || tick) begin
      osc_cnt_q <= '0;
    end else if (seq_q.run) begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  // Sequencer: stages and phase move on a toggle; run is set by a start and cleared on the last toggle
  logic run_stop;
  assign run_stop = seq_q.e && seq_q.d && !seq_q.c;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      seq_q <= '0;
    end else if (start_evt) begin
      seq_q.run <= 1'b1;
    end else if (tick) begin
      seq_q.a <= !seq_q.d;
      seq_q.b <= seq_q.a;
      seq_q.c <= seq_q.b;
      seq_q.d <= seq_q.c;
      if (!seq_q.c && seq_q.d) begin
        seq_q.e <= !seq_q.e;
      end
      if (run_stop) begin
        seq_q.run <= 1'b0;
      end
    end
  end

  // Drive pulses, registered from the stage decode
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      drive_q <= '0;
    end else begin
      drive_q.early_read_pulse <= seq_q.run && !seq_q.e && seq_q.a && !seq_q.d;
      drive_q.late_read_pulse <= seq_q.run && !seq_q.e && seq_q.d;
      drive_q.inhibit_drive_pulse <= seq_q.run && seq_q.e && (seq_q.a || seq_q.d);
      drive_q.write_drive_pulse <= seq_q.run && seq_q.e && seq_q.b;
    end
  end

  // Kind of cycle: processor read or write, DMA read or write
  logic cpu_owner_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      read_cycle_flag <= 1'b0;
      cpu_owner_q <= 1'b0;
    end else if (start_evt) begin
      read_cycle_flag <= cpu_evt && cpu_read_s;
      cpu_owner_q <= cpu_evt;
    end else if (!seq_q.run) begin
      read_cycle_flag <= 1'b0;
    end
  end

  // Toggles at the start of the cycle, at the end of read capture and at the read/write boundary
  logic capture_tick, check_tick, first_tick;
  assign first_tick = tick && !seq_q.e && !seq_q.a && !seq_q.d;
  assign capture_tick = tick && !seq_q.e && seq_q.c && !seq_q.d;
  assign check_tick = tick && !seq_q.e && !seq_q.c && seq_q.d;

  logic rx_par_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || first_tick) begin
      rx_par_q <= 1'b0;
    end else if (capture_tick) begin
      rx_par_q <= sense_par2_q;
    end
  end

  logic gen_par;
  logic is_write;
  assign gen_par = odd_parity(mdata_s);
  // A DMA channel flags writes itself; a processor cycle is a write if not a read
  assign is_write = cpu_owner_q ? !read_cycle_flag : chan_wr_s;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      generated_parity_bit <= 1'b0;
      parity_write_bit <= 1'b0;
    end else begin
      generated_parity_bit <= gen_par;
      if (check_tick) begin
        parity_write_bit <= is_write ? gen_par : rx_par_q;
      end
    end
  end

  // Fail pulse lasts one clock; parity_module_present low disables it
  logic fail_cond;
  assign fail_cond = check_tick && ctrl_chk_q && read_cycle_flag && par_present_s &&
                     cpu_busy_s && busy_hold_s && dbus_busy_n_s &&
                     (gen_par != rx_par_q);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      parity_fail_flag <= 1'b0;
    end else begin
      parity_fail_flag <= fail_cond;
    end
  end

  // Cycle counter for software
  logic [31:0] cycles_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cycles_q <= '0;
    end else if (start_evt) begin
      cycles_q <= cycles_q + 32'h0000_0001;
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  cmt_wr_state_e wr_state_q;
  logic aw_got_q, w_got_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do;
  assign wr_do = (wr_state_q == CMT_WR_IDLE) && aw_got_q && w_got_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wr_do) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  logic aw_next_got, w_next_got;
  assign aw_next_got = aw_got_q || (s_axi_awvalid && s_axi_awready);
  assign w_next_got = w_got_q || (s_axi_wvalid && s_axi_wready);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= (wr_state_q == CMT_WR_IDLE) && !wr_do && !aw_next_got;
      s_axi_wready <= (wr_state_q == CMT_WR_IDLE) && !wr_do && !w_next_got;
    end
  end

  logic wr_hit;
  assign wr_hit = (awaddr_q == `CMT_OFF_CTRL) || (awaddr_q == `CMT_OFF_ERR) ||
                  (awaddr_q == `CMT_OFF_STATUS) || (awaddr_q == `CMT_OFF_CYCLES);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_state_q <= CMT_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMT_RESP_OKAY;
    end else begin
      case (wr_state_q)
        CMT_WR_IDLE: begin
          if (wr_do) begin
            wr_state_q <= CMT_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CMT_RESP_OKAY : `CMT_RESP_SLVERR;
          end
        end
        CMT_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= CMT_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= CMT_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Control register; read-only registers ignore writes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      {ctrl_chk_q, ctrl_en_q} <= `CMT_CTRL_RST;
    end else if (wr_do && (awaddr_q == `CMT_OFF_CTRL) && wstrb_q[0]) begin
      ctrl_en_q <= wdata_q[`CMT_CTRL_EN];
      ctrl_chk_q <= wdata_q[`CMT_CTRL_CHK];
    end
  end

  // Sticky parity error, write one to clear; a new failure wins over the clear
  logic err_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      err_q <= 1'b0;
    end else if (fail_cond) begin
      err_q <= 1'b1;
    end else if (wr_do && (awaddr_q == `CMT_OFF_ERR) && wstrb_q[0] &&
                 wdata_q[`CMT_ERR_PFAIL]) begin
      err_q <= 1'b0;
    end
  end

  // AXI4-Lite read side: one read at a time, answer one clock after address
  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[`CMT_ST_RUN] = seq_q.run;
    status_w[`CMT_ST_PHASE] = seq_q.e;
    status_w[`CMT_ST_SEQ_LO +: 4] = {seq_q.d, seq_q.c, seq_q.b, seq_q.a};
    status_w[`CMT_ST_RDFLAG] = read_cycle_flag;
    status_w[`CMT_ST_RXPAR] = rx_par_q;
    status_w[`CMT_ST_GENPAR] = gen_par;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CMT_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CMT_RESP_OKAY;
      case (s_axi_araddr)
        `CMT_OFF_CTRL: s_axi_rdata <= {30'h0, ctrl_chk_q, ctrl_en_q};
        `CMT_OFF_STATUS: s_axi_rdata <= status_w;
        `CMT_OFF_ERR: s_axi_rdata <= {31'h0, err_q};
        `CMT_OFF_CYCLES: s_axi_rdata <= cycles_q;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `CMT_RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  AST_RUN_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    start_evt |=> seq_q.run ##1 (osc_cnt_q == 8'h01))
    else $error("run not set by start");

  AST_ONE_BIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick |=> $countones({seq_q.d, seq_q.c, seq_q.b, seq_q.a} ^
                        $past({seq_q.d, seq_q.c, seq_q.b, seq_q.a})) == 1)
    else $error("stage change not single bit");

  AST_REST: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !seq_q.run |-> ({seq_q.e, seq_q.d, seq_q.c, seq_q.b, seq_q.a} == 5'h00))
    else $error("sequencer not at rest");

  AST_FIRST_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    first_tick |=> seq_q.a && !seq_q.b ##0 (!tick)[*5] ##1 tick ##1 seq_q.b)
    else $error("stage order wrong");

  AST_PHASE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tick && !(seq_q.d && !seq_q.c)) |=> $stable(seq_q.e))
    else $error("phase toggled outside window");

  AST_RUN_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tick && run_stop) |=> !seq_q.run ##1 (!seq_q.run || $past(start_evt)))
    else $error("run not cleared at end");

  AST_TICK_GAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick |=> (!tick)[*5])
    else $error("toggle spacing below period");

  AST_FAIL_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    parity_fail_flag |-> err_q ##1 !parity_fail_flag)
    else $error("fail flag longer than one clock");

  AST_FAIL_QUAL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (check_tick && (gen_par == rx_par_q)) |=> !parity_fail_flag)
    else $error("fail on matching parity");

  AST_PAR_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    first_tick |=> !rx_par_q)
    else $error("captured parity not cleared");

  AST_WR_PAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (check_tick && is_write) |=> (parity_write_bit == $past(gen_par)))
    else $error("write parity not generated value");

endmodule
`default_nettype wire

// file: cmt_mem_model.sv
/*
  Behavioural core memory module that answers the drive pulses.
  Assumes the bench supplies the stored word on the data bus and the
  stored parity bit.
*/
`timescale 1ns/1ps
`default_nettype none

module cmt_mem_model
  import cmt_pkg::*;
(
  // Clock and drive pulses
  input wire logic sys_clk,
  input wire cmt_drive_s drive,
  // Stored contents
  input wire logic [15:0] word,
  input wire logic par,
  input wire logic has_par,
  // Memory side
  output logic [16:0] memory_sense_bus,
  output logic parity_module_present
);
  logic [16:0] sense_q = 17'h00000;

  // Without parity storage the strap stays inactive; bit 16 then carries the inverted word parity
  assign parity_module_present = has_par;
  assign memory_sense_bus = sense_q;

  // Sense lines churn when released, so a late capture cannot pass by luck
  always @(posedge sys_clk) begin
    if (drive.early_read_pulse || drive.late_read_pulse) begin
      sense_q <= {has_par ? par : ~^word, word};
    end else begin
      sense_q <= ~sense_q;
    end
  end
endmodule

`default_nettype wire

// file: cmt_core_memory_timing_bench.sv
/*
  Self-checking bench of the core-memory timing and parity block.
  Assumes cmt_pkg, the design and cmt_mem_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module cmt_core_memory_timing_bench
  import cmt_pkg::*;
;
  localparam int OC = 6;
  localparam int EW [4] = '{4 * OC, 7 * OC, 4 * OC, 3 * OC};

  logic sys_clk = 1'b0, reset_n = 1'b0;
  logic dma_cycle_start = 1'b0, cpu_cycle_start = 1'b0, cpu_read_req = 1'b0;
  logic channel_write_active = 1'b0, cpu_memory_busy = 1'b1, cpu_busy_hold = 1'b1;
  logic data_bus_busy_n = 1'b1, stored_par = 1'b0, has_par = 1'b1;
  logic [15:0] memory_data_bus = 16'h0000;
  wire logic [16:0] memory_sense_bus;
  wire logic parity_module_present;
  cmt_drive_s drive_q;
  logic generated_parity_bit, parity_write_bit, read_cycle_flag, parity_fail_flag;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic [31:0] s_axi_rdata, bd;
  int miscompares = 0, n_tests = 0, cyc = 0, ncyc = 0, pf = 0;
  int w [4];
  logic rdf;

  always #5 sys_clk = ~sys_clk;

  cmt_core_memory_timing #(.OSC_CYCLES(OC), .DATA_W(16)) DUT (
    .sys_clk, .reset_n, .dma_cycle_start, .cpu_cycle_start, .cpu_read_req,
    .channel_write_active, .cpu_memory_busy, .cpu_busy_hold, .data_bus_busy_n,
    .parity_module_present, .memory_data_bus, .memory_sense_bus, .drive_q,
    .generated_parity_bit, .parity_write_bit, .read_cycle_flag, .parity_fail_flag,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  cmt_mem_model mem (
    .sys_clk(sys_clk), .drive(drive_q), .word(memory_data_bus), .par(stored_par),
    .has_par(has_par), .memory_sense_bus(memory_sense_bus),
    .parity_module_present(parity_module_present)
  );

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hung handshake or cycle lands here rather than running forever
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, wd;
    aw = 1'b1;
    wd = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wd && s_axi_wready) begin
        wd = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        bd = s_axi_rdata;
        br = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // One strobe, then watch the whole cycle; again raises a DMA strobe mid-run
  task automatic run_cycle(input logic cpu, input logic dma, input logic rd, input logic again);
    w = '{default: 0};
    pf = 0;
    rdf = 1'b0;
    @(posedge sys_clk);
    cpu_read_req <= rd;
    cpu_cycle_start <= cpu;
    dma_cycle_start <= dma;
    for (int i = 0; i < 130; i++) begin
      @(posedge sys_clk);
      if (again && i == 40) dma_cycle_start <= 1'b1;
      for (int k = 0; k < 4; k++) w[k] += drive_q[k];
      pf += parity_fail_flag;
      rdf |= read_cycle_flag;
    end
    cpu_cycle_start <= 1'b0;
    dma_cycle_start <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic check_cycle(input logic on, input int epf, input logic erdf, input logic epw);
    for (int k = 0; k < 4; k++) chk(w[k], on ? EW[k] : 0);
    chk(pf, epf);
    chk(rdf, erdf);
    if (on) chk(parity_write_bit, epw);
    axi_rd(4'h4);
    chk(bd & 32'h3F, 32'h0);
    ncyc += on;
    axi_rd(4'hC);
    chk(bd, ncyc);
  endtask

  task automatic set_word(input logic [15:0] wd, input logic p, input logic gen);
    memory_data_bus <= wd;
    stored_par <= p;
    repeat (5) @(posedge sys_clk);
    chk(generated_parity_bit, gen);
  endtask

  task automatic t_reset;
    chk({drive_q, parity_write_bit, read_cycle_flag, parity_fail_flag}, 0);
    axi_rd(4'h0);
    chk(bd, 32'h3);
    chk(br, 2'h0);
    axi_rd(4'h2);
    chk(br, 2'h2);
    axi_wr(4'h2, 32'h00000000);
    chk(br, 2'h2);
    axi_wr(4'h4, 32'hFFFFFFFF);
    chk(br, 2'h0);
    axi_rd(4'h4);
    chk(bd, 32'h0);
  endtask

  task automatic t_reads;
    set_word(16'hA5C3, 1'b0, 1'b0);
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    set_word(16'h0001, 1'b1, 1'b1);
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b1);
    set_word(16'h0007, 1'b0, 1'b1);
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 1, 1'b1, 1'b0);
    axi_rd(4'h8);
    chk(bd[0], 1'b1);
    axi_wr(4'h8, 32'h1);
    axi_rd(4'h8);
    chk(bd[0], 1'b0);
  endtask

  // Each qualifier of the fail report except the read flag is dropped in turn
  task automatic t_suppress;
    has_par <= 1'b0;
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    has_par <= 1'b1;
    data_bus_busy_n <= 1'b0;
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    data_bus_busy_n <= 1'b1;
    cpu_busy_hold <= 1'b0;
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    cpu_busy_hold <= 1'b1;
    cpu_memory_busy <= 1'b0;
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    cpu_memory_busy <= 1'b1;
    // Check enable off: the same mismatch must stay silent
    axi_wr(4'h0, 32'h1);
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    axi_wr(4'h0, 32'h3);
  endtask

  task automatic t_writes;
    channel_write_active <= 1'b1;
    run_cycle(1'b0, 1'b1, 1'b0, 1'b0);
    check_cycle(1'b1, 0, 1'b0, 1'b1);
    channel_write_active <= 1'b0;
    set_word(16'h0003, 1'b1, 1'b0);
    run_cycle(1'b1, 1'b0, 1'b0, 1'b0);
    check_cycle(1'b1, 0, 1'b0, 1'b0);
  endtask

  task automatic t_refuse;
    axi_wr(4'h0, 32'h2);
    set_word(16'hA5C3, 1'b0, 1'b0);
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    check_cycle(1'b0, 0, 1'b0, 1'b0);
    axi_wr(4'h0, 32'h3);
    run_cycle(1'b1, 1'b0, 1'b1, 1'b1);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
    run_cycle(1'b1, 1'b1, 1'b1, 1'b0);
    check_cycle(1'b1, 0, 1'b1, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_reads;
    t_suppress;
    t_writes;
    t_refuse;
    wrap_up;
  end
endmodule

`default_nettype wire
